// ### src/flash_host_pkg.sv
package flash_host_pkg;

  // Flash bus geometry, word mode
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // Clock and flash bus timing
  localparam int CLK_NS = 20;
  localparam int T_ACC_NS = 55;
  localparam int T_WP_NS = 35;
  localparam logic [1:0] ACC_CNT = 2'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] WP_CNT = 2'((T_WP_NS + CLK_NS - 1) / CLK_NS);

  // Controller register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;

  // Command register fields
  localparam int CMD_NOWAIT_BIT = 4;

  // Controller status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_TOG1 = 4;
  localparam int ST_TOG2 = 5;
  localparam int ST_ETIMER = 6;
  localparam int ST_READY = 7;
  localparam int ST_POLL = 8;

  // Device status byte fields
  localparam int POLLING_BIT = 7;
  localparam int TOGGLE_BIT_ONE = 6;
  localparam int TIMING_LIMIT_FLAG = 5;
  localparam int ERASE_TIMER_FLAG = 3;
  localparam int SECTOR_TOGGLE_BIT = 2;

  // Device command cycles
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] PROGRAM_CMD = 8'ha0;
  localparam logic [7:0] ERASE_SETUP_CMD = 8'h80;
  localparam logic [7:0] CHIP_ERASE_CMD = 8'h10;
  localparam logic [7:0] SECTOR_ERASE_CMD = 8'h30;
  localparam logic [7:0] SUSPEND_CMD = 8'hb0;
  localparam logic [7:0] RESUME_CMD = 8'h30;
  localparam logic [7:0] RESET_CMD = 8'hf0;

  // Operations software may order, in code order 0..9
  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ADD_SECTOR,
    OP_SUSPEND, OP_RESUME, OP_RESET, OP_POLL, OP_PROBE
  } op_e;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_req_s;

  typedef struct packed {
    bus_req_s req;
    logic last;
  } cmd_step_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } flash_pins_s;

endpackage : flash_host_pkg

// ### src/flash_bus_cycle.sv
`timescale 1ns/10ps
module flash_bus_cycle (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input flash_host_pkg::bus_req_s req,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  output logic done,
  output logic [flash_host_pkg::DATA_W-1:0] rd_data,
  output flash_host_pkg::flash_pins_s pins
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} bus_state_e;

  bus_state_e st_r, st_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  flash_pins_s pins_r, pins_nxt;

  // One strobed cycle; chip select drops between cycles so every read is a fresh one
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rd_nxt = rd_r;
    pins_nxt = pins_r;
    unique case (st_r)
      B_IDLE:
        if (start)
        begin
          pins_nxt.ce_n = 1'b0;
          pins_nxt.oe_n = req.write;
          pins_nxt.addr = req.addr;
          pins_nxt.dq_o = req.data;
          pins_nxt.dq_oe = req.write;
          wr_nxt = req.write;
          st_nxt = B_SETUP;
        end
      B_SETUP:
      begin
        pins_nxt.we_n = ~wr_r;
        cnt_nxt = wr_r ? WP_CNT : ACC_CNT;
        st_nxt = B_STROBE;
      end
      B_STROBE:
        if (cnt_r <= 2'h1)
        begin
          // Write data latch on this rising edge of the write strobe
          pins_nxt.we_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          if (!wr_r)
            rd_nxt = dq_i;
          st_nxt = B_HOLD;
        end
        else
          cnt_nxt = cnt_r - 2'h1;
      B_HOLD:
      begin
        // Data held one cycle past the strobe for hold time
        pins_nxt.ce_n = 1'b1;
        pins_nxt.dq_oe = 1'b0;
        done_nxt = 1'b1;
        st_nxt = B_IDLE;
      end
    endcase
  end

  // Registers; control pins idle high and data undriven after reset
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r <= B_IDLE;
      cnt_r <= 2'h0;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      rd_r <= '0;
      pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      rd_r <= rd_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign done = done_r;
  assign rd_data = rd_r;
  assign pins = pins_r;

endmodule : flash_bus_cycle

// ### src/flash_status_host.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// - Read twice, compare toggle bit, unchanged means done
// - Toggling with limit flag: recheck, reset if still toggling
// - Resumed polling restarts from first double read
// - After limit failure, host writes reset command
// - Ignore timer flag only with short spacing
// - Check timer flag before and after addition
// - Both toggle bits give sector and mode
module flash_status_host (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ready_busy_output,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  output flash_host_pkg::flash_pins_s flash
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_PRE, S_POST, S_POLL_A, S_POLL_B, S_EVAL, S_ARRAY
  } host_state_e;

  // Command cycle table: unlock pair, then the operation's own cycles, for program and both erases; other orders are one cycle
  function automatic cmd_step_s cmd_step(input op_e op, input logic [2:0] idx,
                                         input logic [ADDR_W-1:0] a,
                                         input logic [DATA_W-1:0] d);
    cmd_step_s s;
    s.req.write = 1'b1;
    s.req.addr = a;
    s.req.data = d;
    s.last = 1'b0;
    unique case (op)
      OP_SUSPEND:
      begin
        s.req.data = {8'h00, SUSPEND_CMD};
        s.last = 1'b1;
      end
      OP_RESUME:
      begin
        s.req.data = {8'h00, RESUME_CMD};
        s.last = 1'b1;
      end
      OP_RESET:
      begin
        s.req.data = {8'h00, RESET_CMD};
        s.last = 1'b1;
      end
      OP_ADD_SECTOR:
      begin
        // A further sector needs only its own erase cycle within the time-out
        s.req.data = {8'h00, SECTOR_ERASE_CMD};
        s.last = 1'b1;
      end
      default:
      begin
        if (idx == 3'h0 || idx == 3'h3)
        begin
          s.req.addr = UNLOCK1_ADDR;
          s.req.data = {8'h00, UNLOCK1_DATA};
        end
        else if (idx == 3'h1 || idx == 3'h4)
        begin
          s.req.addr = UNLOCK2_ADDR;
          s.req.data = {8'h00, UNLOCK2_DATA};
        end
        else if (idx == 3'h2)
        begin
          s.req.addr = UNLOCK1_ADDR;
          s.req.data = {8'h00, (op == OP_PROGRAM) ? PROGRAM_CMD : ERASE_SETUP_CMD};
        end
        if (op == OP_PROGRAM && idx == 3'h3)
        begin
          s.req.addr = a;
          s.req.data = d;
          s.last = 1'b1;
        end
        else if (idx == 3'h5)
        begin
          s.req.addr = (op == OP_CHIP_ERASE) ? UNLOCK1_ADDR : a;
          s.req.data = {8'h00, (op == OP_CHIP_ERASE) ? CHIP_ERASE_CMD : SECTOR_ERASE_CMD};
          s.last = 1'b1;
        end
      end
    endcase
    return s;
  endfunction : cmd_step

  host_state_e st_r, st_nxt;
  op_e op_r, op_nxt;
  logic [2:0] step_r, step_nxt;
  logic wait_r, wait_nxt;
  logic start_r, start_nxt;
  bus_req_s req_r, req_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic [DATA_W-1:0] first_r, first_nxt;
  logic [DATA_W-1:0] result_r, result_nxt;
  logic nowait_r, nowait_nxt;
  logic recheck_r, recheck_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic reject_r, reject_nxt;
  logic tog1_r, tog1_nxt;
  logic tog2_r, tog2_nxt;
  logic etimer_r, etimer_nxt;
  logic ready_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic bus_done;
  logic [DATA_W-1:0] bus_rd;
  logic busy;
  logic tog1_now;
  cmd_step_s step_now;

  assign busy = (st_r != S_IDLE);
  // Current command cycle, looked up once for both the launch and the end test
  assign step_now = cmd_step(op_r, step_r, addr_r, data_r);
  // Toggle bit one compared between the stored first read and the fresh second
  assign tog1_now = first_r[TOGGLE_BIT_ONE] ^ bus_rd[TOGGLE_BIT_ONE];

  // Sequencer: command cycles, toggle polling and erase-timer checks
  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    step_nxt = step_r;
    wait_nxt = wait_r;
    start_nxt = 1'b0;
    req_nxt = req_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    first_nxt = first_r;
    result_nxt = result_r;
    nowait_nxt = nowait_r;
    recheck_nxt = recheck_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    reject_nxt = reject_r;
    tog1_nxt = tog1_r;
    tog2_nxt = tog2_r;
    etimer_nxt = etimer_r;
    unique case (st_r)
      S_IDLE:
      begin
        // Address and data are frozen while an order runs
        if (reg_wr && reg_addr == REG_ADDR)
          addr_nxt = reg_wdata[ADDR_W-1:0];
        if (reg_wr && reg_addr == REG_DATA)
          data_nxt = reg_wdata[DATA_W-1:0];
        if (reg_wr && reg_addr == REG_CMD && reg_wdata[3:0] <= 4'h9)
        begin
          op_nxt = op_e'(reg_wdata[3:0]);
          nowait_nxt = reg_wdata[CMD_NOWAIT_BIT];
          step_nxt = 3'h0;
          recheck_nxt = 1'b0;
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          reject_nxt = 1'b0;
          unique case (op_e'(reg_wdata[3:0]))
            OP_READ: st_nxt = S_ARRAY;
            OP_ADD_SECTOR: st_nxt = S_PRE;
            OP_POLL, OP_PROBE: st_nxt = S_POLL_A;
            default: st_nxt = S_ISSUE;
          endcase
        end
      end
      S_ISSUE:
        if (!wait_r)
        begin
          req_nxt = step_now.req;
          start_nxt = 1'b1;
          wait_nxt = 1'b1;
        end
        else if (bus_done)
        begin
          wait_nxt = 1'b0;
          step_nxt = step_r + 3'h1;
          if (step_now.last)
          begin
            if (op_r == OP_RESET)
            begin
              done_nxt = 1'b1;
              st_nxt = S_IDLE;
            end
            else if (op_r == OP_ADD_SECTOR || (op_r == OP_SECTOR_ERASE && nowait_r))
              st_nxt = S_POST;
            else
              st_nxt = S_POLL_A;
          end
        end
      S_PRE, S_POST, S_POLL_A, S_POLL_B, S_ARRAY:
        if (!wait_r)
        begin
          req_nxt = '{write: 1'b0, addr: addr_r, data: '0};
          start_nxt = 1'b1;
          wait_nxt = 1'b1;
        end
        else if (bus_done)
        begin
          wait_nxt = 1'b0;
          result_nxt = bus_rd;
          if (st_r == S_PRE)
          begin
            etimer_nxt = bus_rd[ERASE_TIMER_FLAG];
            // Erase already running: a further sector would be ignored
            if (bus_rd[ERASE_TIMER_FLAG])
            begin
              reject_nxt = 1'b1;
              done_nxt = 1'b1;
              st_nxt = S_IDLE;
            end
            else
              st_nxt = S_ISSUE;
          end
          else if (st_r == S_POST)
          begin
            etimer_nxt = bus_rd[ERASE_TIMER_FLAG];
            reject_nxt = (op_r == OP_ADD_SECTOR) && bus_rd[ERASE_TIMER_FLAG];
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
          end
          else if (st_r == S_POLL_A)
          begin
            first_nxt = bus_rd;
            st_nxt = S_POLL_B;
          end
          else if (st_r == S_POLL_B)
            st_nxt = S_EVAL;
          else
          begin
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
          end
        end
      S_EVAL:
      begin
        tog1_nxt = tog1_now;
        tog2_nxt = first_r[SECTOR_TOGGLE_BIT] ^ result_r[SECTOR_TOGGLE_BIT];
        etimer_nxt = result_r[ERASE_TIMER_FLAG];
        if (op_r == OP_PROBE || !tog1_now)
        begin
          done_nxt = 1'b1;
          st_nxt = S_IDLE;
        end
        else if (recheck_r)
        begin
          // Still toggling after the limit was seen: the operation failed
          fail_nxt = 1'b1;
          op_nxt = OP_RESET;
          st_nxt = S_ISSUE;
        end
        else
        begin
          // Limit may rise just as toggling stops, so look once more
          recheck_nxt = result_r[TIMING_LIMIT_FLAG];
          st_nxt = S_POLL_A;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Register read port; data valid only the cycle after the strobe
  always_comb
  begin
    rdata_nxt = 32'h0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_ADDR: rdata_nxt = {13'h0, addr_r};
        REG_DATA: rdata_nxt = {16'h0, data_r};
        REG_RESULT: rdata_nxt = {16'h0, result_r};
        REG_STATUS:
        begin
          rdata_nxt[ST_BUSY] = busy;
          rdata_nxt[ST_DONE] = done_r;
          rdata_nxt[ST_FAIL] = fail_r;
          rdata_nxt[ST_REJECT] = reject_r;
          rdata_nxt[ST_TOG1] = tog1_r;
          rdata_nxt[ST_TOG2] = tog2_r;
          rdata_nxt[ST_ETIMER] = etimer_r;
          rdata_nxt[ST_READY] = ready_r;
          rdata_nxt[ST_POLL] = result_r[POLLING_BIT];
        end
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r <= S_IDLE;
      op_r <= OP_READ;
      step_r <= 3'h0;
      wait_r <= 1'b0;
      start_r <= 1'b0;
      req_r <= '0;
      addr_r <= '0;
      data_r <= '0;
      first_r <= '0;
      result_r <= '0;
      nowait_r <= 1'b0;
      recheck_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      reject_r <= 1'b0;
      tog1_r <= 1'b0;
      tog2_r <= 1'b0;
      etimer_r <= 1'b0;
      ready_r <= 1'b0;
      rdata_r <= 32'h0;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      wait_r <= wait_nxt;
      start_r <= start_nxt;
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      first_r <= first_nxt;
      result_r <= result_nxt;
      nowait_r <= nowait_nxt;
      recheck_r <= recheck_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      reject_r <= reject_nxt;
      tog1_r <= tog1_nxt;
      tog2_r <= tog2_nxt;
      etimer_r <= etimer_nxt;
      ready_r <= ready_busy_output;
      rdata_r <= rdata_nxt;
    end
  end

  // Pin timing lives in the cycle engine
  flash_bus_cycle u_bus (
    .mclk(mclk),
    .rstn(rstn),
    .start(start_r),
    .req(req_r),
    .dq_i(dq_i),
    .done(bus_done),
    .rd_data(bus_rd),
    .pins(flash)
  );

  assign reg_rdata = rdata_r;

endmodule : flash_status_host

// ### verification/flash_status_host_assertions.sv
`timescale 1ns/10ps
module flash_status_host_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic ready_busy_output,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  input flash_host_pkg::flash_pins_s flash
);
  import flash_host_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Register port answers only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  // Device strobes: write only while selected and driving, never with output enable
  strobe_select_a: assert property (!flash.we_n |-> !flash.ce_n && flash.dq_oe)
    else $error("write strobe without select or data");
  no_contention_a: assert property (!flash.oe_n |-> !flash.dq_oe && flash.we_n)
    else $error("host drives bus during read");
  write_pulse_a: assert property ($fell(flash.we_n) |=> !flash.we_n ##1 flash.we_n)
    else $error("write pulse not two cycles");
  read_hold_a: assert property ($fell(flash.oe_n) |-> (!flash.oe_n)[*4] ##1 flash.oe_n)
    else $error("read access not four cycles");

  // Each status read is a fresh cycle, so toggles can be seen
  select_gap_a: assert property ($rose(flash.ce_n) |=> flash.ce_n)
    else $error("select gap too short");
  addr_stable_a: assert property (!flash.ce_n && !$past(flash.ce_n) |-> $stable(flash.addr))
    else $error("address moved inside a cycle");

  prog_cmd_c: cover property (!flash.we_n && flash.dq_o[7:0] == PROGRAM_CMD);
  reset_cmd_c: cover property (!flash.we_n && flash.dq_o[7:0] == RESET_CMD);
  busy_pin_c: cover property ($fell(ready_busy_output));
endmodule : flash_status_host_checker

bind flash_status_host flash_status_host_checker u_chk (.mclk(mclk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ready_busy_output(ready_busy_output), .dq_i(dq_i), .flash(flash));

// ### verification/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model #(
  parameter int TO_READS = 3
) (
  input flash_host_pkg::flash_pins_s flash,
  input wire logic stuck,
  input wire logic [7:0] busy_reads,
  output logic [flash_host_pkg::DATA_W-1:0] dq,
  output logic ready_busy_output,
  output logic [flash_host_pkg::ADDR_W-1:0] prog_addr,
  output logic [flash_host_pkg::DATA_W-1:0] prog_data,
  output logic [7:0] last_cmd
);
  import flash_host_pkg::*;
  bit busy, susp, erase, armed, tog1, tog2, tmr, lim;
  bit [DATA_W-1:0] held;
  int left, nrd;
  logic pol;
  logic [7:0] stat;
  logic [DATA_W-1:0] word;
  logic prot;

  // Busy reads give status; a released bus shows the inverse, not a kept value
  assign pol = (busy && !susp) ? (!erase && !prog_data[7]) : 1'b1;
  assign stat = {pol, tog1, lim, 1'b0, tmr, tog2, 2'b00};
  assign word = busy ? {8'h00, stat} : flash.addr[15:0] ^ 16'h5a5a;
  assign dq = (!flash.ce_n && !flash.oe_n) ? word : ~held;
  assign ready_busy_output = !(busy && !susp);
  // Top sector stands in for a protected one: commands there only toggle briefly
  assign prot = (flash.addr[ADDR_W-1:12] == 7'h7f);

  task automatic go(input bit e, input bit t);
    busy = 1'b1;
    erase = e;
    susp = 1'b0;
    lim = 1'b0;
    tmr = t;
    left = busy_reads;
    nrd = 0;
  endtask : go

  // Commands act at the rising edge of the last write strobe
  always @(posedge flash.we_n)
    if (!flash.ce_n)
    begin
      last_cmd = flash.dq_o[7:0];
      if (armed)
      begin
        armed = 1'b0;
        // A protected program leaves the array untouched
        if (!prot)
        begin
          prog_addr = flash.addr;
          prog_data = flash.dq_o;
        end
        go(1'b0, 1'b0);
        if (prot)
          left = 1;
      end
      else
        case (last_cmd)
          PROGRAM_CMD: armed = !busy;
          CHIP_ERASE_CMD: go(1'b1, 1'b1);
          SECTOR_ERASE_CMD: if (susp) susp = 1'b0;
            else if (!busy)
            begin
              go(1'b1, 1'b0);
              if (prot)
                left = 1;
            end
            else if (erase && !tmr)
              go(1'b1, 1'b0);
          SUSPEND_CMD: if (busy && erase) susp = 1'b1;
          RESET_CMD: busy = busy && !lim;
          default: armed = 1'b0;
        endcase
    end

  // Each read while busy and not suspended advances the algorithm and flips tog1; erase reads while busy also flip tog2
  always @(posedge flash.oe_n)
    if (!flash.ce_n)
    begin
      held = word;
      if (busy && erase)
        tog2 = !tog2;
      if (busy && !susp)
      begin
        tog1 = !tog1;
        nrd++;
        tmr = tmr || nrd >= TO_READS;
        if (left > 0)
          left--;
        else if (stuck)
          lim = 1'b1;
        else
          busy = 1'b0;
      end
    end
endmodule : flash_dev_model

// ### verification/flash_status_host_test.sv
`timescale 1ns/10ps
module flash_status_host_test;
  import flash_host_pkg::*;
  logic mclk, rstn, reg_wr, reg_rd, rdy, stuck;
  logic [7:0] reg_addr, busy_reads, last_cmd;
  logic [31:0] reg_wdata, reg_rdata, st, v, a, d;
  logic [31:0] seed = 32'h1919;
  logic [ADDR_W-1:0] prog_addr;
  logic [DATA_W-1:0] prog_data, dev_dq, dq_bus;
  flash_pins_s pins;
  int n_errors = 0;
  int compares = 0;

  assign dq_bus = pins.dq_oe ? pins.dq_o : dev_dq;
  flash_status_host DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ready_busy_output(rdy),
    .dq_i(dq_bus), .flash(pins));
  flash_dev_model #(.TO_READS(3)) dev (.flash(pins), .stuck(stuck), .busy_reads(busy_reads),
    .dq(dev_dq), .ready_busy_output(rdy), .prog_addr(prog_addr), .prog_data(prog_data),
    .last_cmd(last_cmd));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected done, fail and reject bits with busy clear
  function logic [31:0] outcome(input logic f, input logic r);
    return {28'h0, r, f, 2'b10};
  endfunction : outcome

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is taken just after the answer edge, once it has settled
  task rd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : rd

  task wait_idle();
    st = 32'h1;
    for (int n = 0; n < 400 && st[ST_BUSY] !== 1'b0; n++)
      rd(REG_STATUS, st);
    // A poll that never ends counts as a mismatch
    chk(32'(st[ST_BUSY]), 32'h0);
  endtask : wait_idle

  task op(input logic [31:0] ad, input logic [31:0] cmd);
    wr(REG_ADDR, ad);
    wr(REG_DATA, d);
    wr(REG_CMD, cmd);
    wait_idle();
  endtask : op

  task report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // A run still going after 60000 clock cycles ends here as a failure
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    {rstn, reg_wr, reg_rd, stuck, reg_addr, busy_reads, reg_wdata} = '0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd(REG_STATUS, v);
    chk(v & 32'h8f, 32'h80);
    rd(8'h14, v);
    chk(v, 32'h0);
    // Random programs, the first with no busy reads; the protected top sector is kept out
    for (int i = 0; i < 6; i++)
    begin
      a = rnd() & 32'h3ffff;
      d = rnd() & 32'hffff;
      busy_reads = (i == 0) ? 8'h0 : 8'(rnd() % 24);
      op(a, 32'h1);
      chk(st & 32'hf, outcome(1'b0, 1'b0));
      chk({13'h0, prog_addr}, a);
      chk({16'h0, prog_data}, d);
      // The last double read saw the toggling stop
      chk(32'(st[ST_TOG1]), 32'h0);
    end
    // Address write during a program is refused
    busy_reads = 8'd20;
    wr(REG_CMD, 32'h1);
    wr(REG_ADDR, ~a);
    wait_idle();
    rd(REG_ADDR, v);
    chk(v, a);
    // Program into the protected top sector: brief toggling, array untouched
    op(a | 32'h7f000, 32'h1);
    chk(st & 32'hf, outcome(1'b0, 1'b0));
    chk({13'h0, prog_addr}, a);
    // Device keeps toggling with the limit flag up: host gives up and resets
    stuck = 1'b1;
    busy_reads = 8'd3;
    op(a, 32'h1);
    chk(st & 32'hf, outcome(1'b1, 1'b0));
    chk({24'h0, last_cmd}, {24'h0, RESET_CMD});
    stuck = 1'b0;
    // Odd count: the last busy read closes a pair, so the final pair is array data
    busy_reads = 8'd5;
    op(a, 32'h2);
    chk(st & 32'h2f, 32'h02);
    // Sector erase, one accepted addition, then one after the timer ran out
    busy_reads = 8'd40;
    op(a, 32'h13);
    chk(st & 32'h9, 32'h0);
    op(a, 32'h4);
    chk(st & 32'h4f, outcome(1'b0, 1'b0));
    // Probe inside the time-out: both toggles seen, timer and polling bit low, pin busy
    op(a, 32'h9);
    chk(st & 32'h1ff, 32'h032);
    op(a, 32'h4);
    chk(st & 32'h4f, 32'h4a);
    op(a, 32'h5);
    chk(st & 32'h183, 32'h182);
    op(a, 32'h6);
    chk(st & 32'h8f, 32'h82);
    op(a, 32'h7);
    chk({24'h0, last_cmd}, {24'h0, RESET_CMD});
    op(a, 32'h8);
    chk(st & 32'hf, outcome(1'b0, 1'b0));
    op(a, 32'h0);
    rd(REG_RESULT, v);
    chk(v, {16'h0, a[15:0] ^ 16'h5a5a});
    report_and_stop();
  end
endmodule : flash_status_host_test
